// >>> shared/chg_ship_pkg.sv
// package: register map, timing constants and shared types for charge timer
package chg_ship_pkg;

  // register offsets (byte addresses on the plain register port)
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;

  // control register field positions
  localparam int TMR_EN_BIT      = 0;
  localparam int SLOW_EN_BIT     = 1;
  localparam int LIMIT_LSB       = 2;
  localparam int CFG_EN_BIT      = 4;
  localparam int SW_DIS_BIT      = 5;
  localparam int SW_DLY_BIT      = 6;
  localparam int CYCLE_EN_BIT    = 7;
  localparam int REG_RST_BIT     = 8;
  localparam int MINSYS_LSB      = 9;
  localparam int CTRL_W          = 12;

  // control reset value: timer on, slow count on, 12 h, charge on,
  // cycle on, min system select 3.5 V code
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'ha9f;

  // status register field positions
  localparam int FAULT_LSB   = 0;
  localparam int MINSYS_FLAG = 2;
  localparam int ICL_FLAG    = 3;
  localparam int IVL_FLAG    = 4;
  localparam int SW_ON_FLAG  = 5;

  localparam logic [1:0] FAULT_TIMER = 2'h3;
  localparam logic [1:0] FAULT_NONE  = 2'h0;

  // fast charge limit selection codes (hours)
  localparam logic [1:0] LIM_5H  = 2'h0;
  localparam logic [1:0] LIM_8H  = 2'h1;
  localparam logic [1:0] LIM_10H = 2'h2;
  localparam logic [1:0] LIM_12H = 2'h3;

  // timing figures in their own units
  localparam longint CLK_HZ          = 10000000;
  localparam longint LOWBAT_HOURS    = 4;
  localparam longint WAKE_DEGLITCH_MS = 1000;
  localparam longint CYCLE_HOLD_MS   = 16000;
  localparam longint SW_OFF_MS       = 250;
  localparam longint SHIP_DELAY_MS   = 12500;
  localparam longint INT_PULSE_US    = 256;

  // prescaler: clock cycles per ms tick, seconds per hour tick, clock cycles per interrupt pulse
  localparam longint MS_CYCLES   = CLK_HZ / 1000;
  localparam longint SEC_PER_HOUR = 3600;
  localparam longint INT_CYCLES  = (INT_PULSE_US * CLK_HZ) / 1000000;

  // analog status inputs
  typedef struct packed {
    logic vin_limit;    // input voltage regulation active
    logic iin_limit;    // input current regulation active
    logic thermal;      // thermal regulation active
    logic min_sys;      // system rail at minimum setting
    logic charge_fault; // fault suspends charging
    logic charging;     // charge in progress
    logic above_lowbat; // battery above low_battery_threshold
    logic restart;      // new charge cycle restart pulse
  } analog_stat_s;

endpackage : chg_ship_pkg

// >>> design/charge_timer_and_ship_mode_ctrl.sv
// charge safety timer and battery switch sequencer
// Summary of operation
// - timer expiry sets fault 11, pulses interrupt
// - limit 4 h below threshold, 12 h above
// - timer enable cleared disables timeout entirely
// - limit field shortens 12 h fast limit
// - regulation active halves timer count rate
// - slow count disabled counts at full rate
// - fault freezes count, resumes afterward
// - restart or enable toggle clears timer
// - min system flag while rail at minimum
// - input current and voltage limit flags
// - disable bit turns switch off, optional delay
// - valid input exits ship mode
// - one second wake low exits ship mode
// - clearing disable re-enables switch, with or without input
// - register reset restores control register defaults
// - sixteen second hold without input power-cycles switch 250 ms
// - cycle enable zero ignores long hold
// - interrupt pulse is 256 us low
`timescale 1ns/1ps
`default_nettype none

module charge_timer_and_ship_mode_ctrl
  import chg_ship_pkg::*;
#(
  parameter int MS_DIV     = int'(MS_CYCLES),    // clocks per ms tick
  parameter int MS_PER_SEC = 1000,               // ms per second tick
  parameter int SEC_PER_HR = int'(SEC_PER_HOUR), // seconds per hour tick
  parameter int DEGLITCH_MS = int'(WAKE_DEGLITCH_MS),
  parameter int HOLD_MS    = int'(CYCLE_HOLD_MS),
  parameter int OFF_MS     = int'(SW_OFF_MS),
  parameter int DELAY_MS   = int'(SHIP_DELAY_MS)
) (
  input  wire logic         sys_clk_i,            // 10 MHz clock
  input  wire logic         arst_n_i,             // async reset, low
  input  wire logic [7:0]   addr_i,               // register address
  input  wire logic [31:0]  wdata_i,              // write data
  input  wire logic         wr_i,                 // write strobe
  input  wire logic         rd_i,                 // read strobe
  output logic      [31:0]  rdata_o,              // read data, next cycle
  input  wire analog_stat_s stat_i,               // analog loop status
  input  wire logic         vbus_good_i,          // valid input supply pin
  input  wire logic         charge_enable_pin_n_i, // charge enable pin
  input  wire logic         wake_button_n_i,      // wake push button
  output logic              battery_switch_o,     // switch gate enable
  output logic              host_interrupt_n_o,   // interrupt, low pulse
  output logic              charge_allowed_o      // charging permitted
);

  // pin synchronisers
  logic [1:0] vbus_sync_reg, ce_sync_reg, wake_sync_reg;
  logic       vbus_prev_reg;  // synchronised input one cycle late
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vbus_sync_reg <= 2'h0;
      vbus_prev_reg <= 1'b0;
      ce_sync_reg   <= 2'h3;
      wake_sync_reg <= 2'h3;
    end else begin
      vbus_sync_reg <= {vbus_sync_reg[0], vbus_good_i};
      vbus_prev_reg <= vbus_sync_reg[1];
      ce_sync_reg   <= {ce_sync_reg[0], charge_enable_pin_n_i};
      wake_sync_reg <= {wake_sync_reg[0], wake_button_n_i};
    end
  end
  wire vbus_s = vbus_sync_reg[1];
  wire vbus_rise = vbus_s & ~vbus_prev_reg;  // input supply appeared
  wire wake_low_s = ~wake_sync_reg[1];

  // time base: ms, second and hour ticks
  logic [15:0] ms_div_reg;
  logic [9:0]  sec_div_reg;
  logic [11:0] hr_div_reg;
  wire ms_tick  = (ms_div_reg == 16'(MS_DIV - 1));
  wire sec_tick = ms_tick & (sec_div_reg == 10'(MS_PER_SEC - 1));
  wire hr_tick  = sec_tick & (hr_div_reg == 12'(SEC_PER_HR - 1));
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ms_div_reg  <= 16'h0;
      sec_div_reg <= 10'h0;
      hr_div_reg  <= 12'h0;
    end else begin
      ms_div_reg <= ms_tick ? 16'h0 : ms_div_reg + 16'h1;
      if (ms_tick)
        sec_div_reg <= sec_tick ? 10'h0 : sec_div_reg + 10'h1;
      if (sec_tick)
        hr_div_reg <= hr_tick ? 12'h0 : hr_div_reg + 12'h1;
    end
  end

  // control register and register port
  logic [CTRL_W-1:0] ctrl_reg;
  logic [1:0]        fault_reg;
  wire wr_ctrl = wr_i & (addr_i == CTRL_OFS);
  wire reg_rst = wr_ctrl & wdata_i[REG_RST_BIT];
  wire [CTRL_W-1:0] ctrl_next =
    reg_rst ? CTRL_RST : {wdata_i[CTRL_W-1:REG_RST_BIT+1], 1'b0,
                          wdata_i[REG_RST_BIT-1:0]};
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) ctrl_reg <= CTRL_RST;
    else if (wr_ctrl) ctrl_reg <= ctrl_next;
  end
  wire       tmr_en   = ctrl_reg[TMR_EN_BIT];
  wire       slow_en  = ctrl_reg[SLOW_EN_BIT];
  wire [1:0] lim_sel  = ctrl_reg[LIMIT_LSB +: 2];
  wire       cfg_en   = ctrl_reg[CFG_EN_BIT];
  wire       sw_dis   = ctrl_reg[SW_DIS_BIT];
  wire       sw_dly   = ctrl_reg[SW_DLY_BIT];
  wire       cycle_en = ctrl_reg[CYCLE_EN_BIT];

  // status word assembled from block state and analog flags
  wire [31:0] status_word = {26'h0, battery_switch_o,
    stat_i.vin_limit,
    stat_i.iin_limit,
    stat_i.min_sys,
    fault_reg};
  wire [31:0] rd_mux = (addr_i == CTRL_OFS)   ? {20'h0, ctrl_reg} :
                       (addr_i == STATUS_OFS) ? status_word : 32'h0;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) rdata_o <= 32'h0;
    else rdata_o <= rd_i ? rd_mux : 32'h0;
  end

  // safety timer limit in hours
  function automatic logic [3:0] limit_hours(input logic [1:0] sel,
                                             input logic above);
    logic [3:0] h;
    h = 4'(LOWBAT_HOURS);
    if (above) begin
      unique case (sel)
        LIM_5H:  h = 4'h5;
        LIM_8H:  h = 4'h8;
        LIM_10H: h = 4'ha;
        LIM_12H: h = 4'hc;
      endcase
    end
    return h;
  endfunction : limit_hours

  // charge enable edge detect for timer restart
  wire charge_on = cfg_en & ~ce_sync_reg[1];
  logic charge_on_reg, half_reg, hr_flag_reg;
  logic [4:0] hours_reg;   // elapsed hours, counted in half-hour-safe form
  wire regulating = stat_i.vin_limit | stat_i.iin_limit | stat_i.thermal;
  wire slow       = slow_en & regulating;
  wire restart    = stat_i.restart | (charge_on != charge_on_reg);
  wire run        = tmr_en & stat_i.charging & ~stat_i.charge_fault
                    & (fault_reg != FAULT_TIMER);
  wire step       = run & hr_tick & (~slow | half_reg);
  wire expire = run & tmr_en &
                (hours_reg >= {1'b0, limit_hours(lim_sel, stat_i.above_lowbat)});
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      charge_on_reg <= 1'b0;
      half_reg      <= 1'b0;
      hours_reg     <= 5'h0;
      fault_reg     <= FAULT_NONE;
      hr_flag_reg   <= 1'b0;
    end else begin
      charge_on_reg <= charge_on;
      hr_flag_reg   <= expire;
      if (restart || !tmr_en) begin
        hours_reg <= 5'h0;
        half_reg  <= 1'b0;
        if (restart) fault_reg <= FAULT_NONE;
      end else begin
        if (run && hr_tick && slow) half_reg <= ~half_reg;
        if (step) hours_reg <= hours_reg + 5'h1;
        if (expire) fault_reg <= FAULT_TIMER;
      end
    end
  end
  wire timer_event = expire & ~hr_flag_reg & ~restart & tmr_en;

  // interrupt pulse generator
  logic [11:0] int_cnt_reg;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      int_cnt_reg        <= 12'h0;
      host_interrupt_n_o <= 1'b1;
    end else begin
      if (timer_event) begin
        int_cnt_reg        <= 12'(INT_CYCLES);
        host_interrupt_n_o <= 1'b0;
      end else if (int_cnt_reg != 12'h0) begin
        int_cnt_reg        <= int_cnt_reg - 12'h1;
        host_interrupt_n_o <= (int_cnt_reg == 12'h1);
      end
    end
  end

  // charge permitted output
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) charge_allowed_o <= 1'b0;
    else charge_allowed_o <= charge_on & ~sw_dis & (fault_reg != FAULT_TIMER);
  end

  // wake button hold counter in ms
  logic [14:0] hold_reg;
  wire hold_long = (hold_reg == 15'(HOLD_MS));
  wire hold_wake = (hold_reg >= 15'(DEGLITCH_MS));
  logic wake_done_reg, cyc_done_reg;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) hold_reg <= 15'h0;
    else if (!wake_low_s) hold_reg <= 15'h0;
    else if (ms_tick && !hold_long) hold_reg <= hold_reg + 15'h1;
  end

  // battery switch sequencer
  typedef enum logic [3:0] {
    SW_ON    = 4'b0001,
    SW_DELAY = 4'b0010,
    SW_SHIP  = 4'b0100,
    SW_CYCLE = 4'b1000
  } sw_state_e;
  sw_state_e sw_state_reg, sw_state_next;
  logic [13:0] sw_cnt_reg;
  logic        sw_dis_reg;
  wire dis_rise = sw_dis & ~sw_dis_reg;
  wire wake_exit = hold_wake & ~wake_done_reg;
  wire long_hold = hold_long & ~cyc_done_reg & cycle_en & ~vbus_s;
  wire ship_exit = wake_exit | ~sw_dis | vbus_rise;
  always_comb begin
    sw_state_next = sw_state_reg;
    unique case (sw_state_reg)
      SW_ON: begin
        if (dis_rise)
          sw_state_next = sw_dly ? SW_DELAY : SW_SHIP;
        else if (long_hold && !sw_dis)
          sw_state_next = SW_CYCLE;
      end
      SW_DELAY: begin
        if (!sw_dis) sw_state_next = SW_ON;
        else if (ms_tick && sw_cnt_reg == 14'(DELAY_MS - 1))
          sw_state_next = SW_SHIP;
      end
      SW_SHIP: begin
        // host clears disable bit with or without input
        if (ship_exit)
          sw_state_next = SW_ON;
      end
      SW_CYCLE: begin
        if (ms_tick && sw_cnt_reg == 14'(OFF_MS - 1))
          sw_state_next = SW_ON;
      end
      default: sw_state_next = SW_ON;
    endcase
  end
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sw_state_reg     <= SW_ON;
      sw_cnt_reg       <= 14'h0;
      sw_dis_reg       <= 1'b0;
      wake_done_reg    <= 1'b0;
      cyc_done_reg     <= 1'b0;
      battery_switch_o <= 1'b1;
    end else begin
      sw_state_reg  <= sw_state_next;
      sw_dis_reg    <= sw_dis;
      wake_done_reg <= wake_low_s & (wake_done_reg | hold_wake);
      cyc_done_reg  <= wake_low_s & (cyc_done_reg | hold_long);
      if (sw_state_next != sw_state_reg) sw_cnt_reg <= 14'h0;
      else if (ms_tick) sw_cnt_reg <= sw_cnt_reg + 14'h1;
      battery_switch_o <= (sw_state_next == SW_ON) | (sw_state_next == SW_DELAY);
    end
  end

endmodule : charge_timer_and_ship_mode_ctrl
`default_nettype wire

// >>> verif/wake_button_model.sv
// push-button model driving the wake pin
`timescale 1ns/1ps
`default_nettype none
module wake_button_model #(
  parameter int MS_DIV = 10  // clocks per ms
) (
  input  wire logic clk_i,          // bench clock
  output var  logic wake_button_n_o // wake pin, low when pressed
);
  // released pin sits high on its pull-up
  initial wake_button_n_o = 1'b1;
  // high to low edge, then held low for ms_len ms
  task automatic press(input int ms_len);
    @(posedge clk_i);
    wake_button_n_o <= 1'b0;
    repeat (ms_len * MS_DIV) @(posedge clk_i);
    wake_button_n_o <= 1'b1;
  endtask : press
endmodule : wake_button_model
`default_nettype wire

// >>> verif/chg_ship_checker.sv
// port assertions for the charge timer and switch sequencer
`timescale 1ns/1ps
`default_nettype none
module chg_ship_checker
  import chg_ship_pkg::*;
#(
  parameter int MS_DIV   = 10, // clocks per ms tick
  parameter int DELAY_MS = 5   // ship entry delay in ms
) (
  input wire logic         sys_clk_i,             // clock
  input wire logic         arst_n_i,              // reset, low
  input wire logic [7:0]   addr_i,                // address
  input wire logic [31:0]  wdata_i,               // write data
  input wire logic         wr_i,                  // write strobe
  input wire logic         rd_i,                  // read strobe
  input wire logic [31:0]  rdata_o,               // read data
  input wire analog_stat_s stat_i,                // loop status
  input wire logic         vbus_good_i,           // valid input
  input wire logic         charge_enable_pin_n_i, // charge pin
  input wire logic         wake_button_n_i,       // wake pin
  input wire logic         battery_switch_o,      // switch on
  input wire logic         host_interrupt_n_o,    // interrupt
  input wire logic         charge_allowed_o       // charge allowed
);
  localparam int DLY_HI = (DELAY_MS + 1) * MS_DIV + 4;
  localparam logic [15:0] PULSE = 16'(INT_CYCLES);
  logic [15:0] low_cnt;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  // length of the running interrupt pulse
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      low_cnt <= '0;
    else
      low_cnt <= host_interrupt_n_o ? '0 : low_cnt + 16'h1;
  end
  // control write that sets the switch disable bit
  sequence ship_write(logic dly);
    wr_i && addr_i == CTRL_OFS && wdata_i[SW_DIS_BIT]
      && wdata_i[SW_DLY_BIT] == dly && !wdata_i[REG_RST_BIT];
  endsequence
  sequence stay_on;
    battery_switch_o [*8];
  endsequence
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  a_rdata_unmapped: assert property (rd_i && addr_i != CTRL_OFS
    && addr_i != STATUS_OFS |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_status_flags: assert property (
    rd_i && addr_i == STATUS_OFS && stat_i == $past(stat_i)
    && stat_i == $past(stat_i, 2) && $past(arst_n_i, 2)
    |=> rdata_o[IVL_FLAG:MINSYS_FLAG] == {$past(stat_i.vin_limit),
    $past(stat_i.iin_limit), $past(stat_i.min_sys)})
    else $error("status flags do not follow loops");
  a_int_length: assert property (
    $rose(host_interrupt_n_o) |-> low_cnt == PULSE)
    else $error("interrupt pulse length wrong");
  a_int_max: assert property (low_cnt <= PULSE)
    else $error("interrupt pulse too long");
  a_int_hold: assert property (
    $fell(host_interrupt_n_o) |=> !host_interrupt_n_o [*8])
    else $error("interrupt pulse cut short");
  a_off_now: assert property (
    ship_write(1'b0) |-> ##2 !battery_switch_o [*3])
    else $error("switch not off after disable");
  a_off_delayed: assert property (
    ship_write(1'b1) and battery_switch_o
    |=> stay_on ##[1:DLY_HI] !battery_switch_o)
    else $error("delayed switch off out of window");
  a_vbus_exit: assert property (
    $rose(vbus_good_i) |-> ##[2:6] battery_switch_o)
    else $error("switch not on after input returns");
endmodule : chg_ship_checker
bind charge_timer_and_ship_mode_ctrl chg_ship_checker #(
  .MS_DIV(MS_DIV), .DELAY_MS(DELAY_MS)) i_chk (
  .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .stat_i(stat_i), .vbus_good_i(vbus_good_i),
  .charge_enable_pin_n_i(charge_enable_pin_n_i),
  .wake_button_n_i(wake_button_n_i),
  .battery_switch_o(battery_switch_o),
  .host_interrupt_n_o(host_interrupt_n_o),
  .charge_allowed_o(charge_allowed_o));
`default_nettype wire

// >>> verif/charge_timer_and_ship_mode_ctrl_tb.sv
// self-checking bench for the charge timer and switch sequencer
`timescale 1ns/1ps
`default_nettype none
module charge_timer_and_ship_mode_ctrl_tb;
  import chg_ship_pkg::*;
  localparam int HR = 160; // clocks per shortened hour
  logic         sys_clk_i, arst_n_i, wr_i, rd_i, vbus_good_i, pin_n;
  logic [7:0]   addr_i;
  logic [31:0]  wdata_i, rdata_o, d;
  logic         sw_o, int_n_o, allow_o, wake_n;
  analog_stat_s stat_i;
  int           errors, num_checks, n;
  charge_timer_and_ship_mode_ctrl #(.MS_DIV(10), .MS_PER_SEC(4),
    .SEC_PER_HR(4), .DEGLITCH_MS(3), .HOLD_MS(8), .OFF_MS(2),
    .DELAY_MS(5)) i_dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .stat_i(stat_i), .vbus_good_i(vbus_good_i),
    .charge_enable_pin_n_i(pin_n), .wake_button_n_i(wake_n),
    .battery_switch_o(sw_o), .host_interrupt_n_o(int_n_o),
    .charge_allowed_o(allow_o));
  wake_button_model #(.MS_DIV(10)) i_btn (.clk_i(sys_clk_i),
    .wake_button_n_o(wake_n));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    @(posedge sys_clk_i);
  endtask : rd
  // expected cycles from restart to timer expiry, 0 when off
  function automatic int expect_cyc(logic [11:0] c, logic iin, ab, int flt);
    int h;
    h = c[3:2] == LIM_5H ? 5 : c[3:2] == LIM_8H ? 8 : c[3:2] == LIM_10H ? 10 : 12;
    if (!ab && h > 4)
      h = 4;
    if (iin && c[SLOW_EN_BIT])
      h = 2 * h;
    return c[TMR_EN_BIT] ? h * HR + flt : 0;
  endfunction : expect_cyc
  // one restart, wait for expiry, then read fault and restart again
  // pin set: thermal loop slows the timer, pin toggle restarts it
  task automatic run(input logic [11:0] c, input logic iin, ab, input int flt,
                     input logic pin);
    int ex;
    ex = expect_cyc(c, iin, ab, flt);
    wr(CTRL_OFS, {20'h0, c});
    {stat_i.iin_limit, stat_i.thermal} <= pin ? {1'b0, iin} : {iin, 1'b0};
    stat_i.above_lowbat <= ab;
    stat_i.restart <= 1'b1;
    @(posedge sys_clk_i);
    stat_i.restart <= 1'b0;
    n = 0;
    while (int_n_o !== 1'b0 && n < (ex == 0 ? 2400 : ex + 400)) begin
      @(posedge sys_clk_i);
      stat_i.charge_fault <= n >= 200 && n < 200 + flt;
      #1 n++;
    end
    if (ex == 0)
      check(int_n_o, 1'b1);
    else if (n >= ex + 400) begin
      errors++;
      close_out();
    end
    else
      check(n > ex - 330 && n < ex + 330, 1'b1);
    cyc(2600);
    rd(STATUS_OFS);
    check(d[1:0], ex != 0 ? FAULT_TIMER : FAULT_NONE);
    check(allow_o, ex == 0);
    if (pin) begin
      pin_n <= 1'b1;
      cyc(4);
      pin_n <= 1'b0;
    end else begin
      stat_i.restart <= 1'b1;
      cyc(1);
      stat_i.restart <= 1'b0;
    end
    cyc(3);
    rd(STATUS_OFS);
    check(d[1:0], FAULT_NONE);
    check(allow_o, 1'b1);
  endtask : run
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // main sequence: registers, flags, timer table, switch control
  initial begin
    void'($urandom(70));
    {arst_n_i, wr_i, rd_i, addr_i, wdata_i} = '0;
    {vbus_good_i, pin_n, stat_i} = {2'b10, 8'h06};
    repeat (10) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    cyc(3);
    rd(CTRL_OFS);
    check(d, {20'h0, CTRL_RST});
    rd(8'h08);
    check(d, 32'h0);
    for (int i = 0; i < 8; i++) begin
      stat_i <= 8'($urandom) & 8'hf6;
      cyc(3);
      rd(STATUS_OFS);
      check(d[4:2], {stat_i.vin_limit, stat_i.iin_limit, stat_i.min_sys});
    end
    stat_i <= 8'h06;
    run(12'ha9f, 0, 1, 0, 0);
    run(12'ha93, 0, 1, 0, 0);
    run(12'ha97, 1, 1, 0, 1);
    run(12'ha95, 1, 1, 0, 0);
    run(12'ha9b, 0, 0, 0, 0);
    run(12'ha93, 0, 1, 800, 1);
    run(12'ha9e, 0, 1, 0, 0);
    for (int v = 0; v < 2; v++) begin
      vbus_good_i <= v[0];
      cyc(3);
      wr(CTRL_OFS, 32'habf);
      cyc(2);
      check(sw_o, 1'b0);
      rd(STATUS_OFS);
      check(d[SW_ON_FLAG], 1'b0);
      wr(CTRL_OFS, 32'ha9f);
      cyc(4);
      check(sw_o, 1'b1);
    end
    vbus_good_i <= 1'b0;
    cyc(3);
    wr(CTRL_OFS, 32'habf);
    vbus_good_i <= 1'b1;
    cyc(6);
    check(sw_o, 1'b1);
    wr(CTRL_OFS, 32'h100);
    vbus_good_i <= 1'b0;
    cyc(3);
    rd(CTRL_OFS);
    check(d, {20'h0, CTRL_RST});
    wr(CTRL_OFS, 32'haff);
    cyc(30);
    check(sw_o, 1'b1);
    cyc(40);
    check(sw_o, 1'b0);
    i_btn.press(4);
    cyc(6);
    check(sw_o, 1'b1);
    wr(CTRL_OFS, 32'h100);
    for (int e = 0; e < 2; e++) begin
      wr(CTRL_OFS, e != 0 ? 32'ha1f : 32'ha9f);
      n = 0;
      fork
        i_btn.press(9);
        repeat (150) begin
          @(posedge sys_clk_i);
          #1 n += int'(!sw_o);
        end
      join
      check(e != 0 ? n == 0 : n > 10 && n < 30, 1'b1);
    end
    close_out();
  end
endmodule : charge_timer_and_ship_mode_ctrl_tb
`default_nettype wire
